// [design/txcfg_pkg.sv]
package txcfg_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] TXCFG_ADDR_DRIVER_MODE  = 8'h28;
    localparam logic [7:0] TXCFG_ADDR_CARRIER_AMP  = 8'h29;
    localparam logic [7:0] TXCFG_ADDR_MOD_CONTROL  = 8'h2a;
    localparam logic [7:0] TXCFG_ADDR_OVERSHOOT    = 8'h2b;
    localparam logic [7:0] TXCFG_ADDR_TX_CRC_SETUP = 8'h2c;

    // ------------------------------------------------------------------
    // writable bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TXCFG_MASK_DRIVER_MODE  = 8'hcf;
    localparam logic [7:0] TXCFG_MASK_CARRIER_AMP  = 8'hdf;
    localparam logic [7:0] TXCFG_MASK_MOD_CONTROL  = 8'hff;
    localparam logic [7:0] TXCFG_MASK_OVERSHOOT    = 8'hff;
    localparam logic [7:0] TXCFG_MASK_TX_CRC_SETUP = 8'h7f;
    localparam logic [7:0] TXCFG_RST_VALUE         = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int TXCFG_BIT_INV_TWO    = 7;
    localparam int TXCFG_BIT_INV_ONE    = 6;
    localparam int TXCFG_BIT_DRV_ON     = 3;
    localparam int TXCFG_BIT_FULL_LEVEL = 3;
    localparam int TXCFG_BIT_MOD_INV    = 2;
    localparam int TXCFG_BIT_CRC_COMPL  = 1;
    localparam int TXCFG_BIT_CRC_APPEND = 0;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TXCFG_SRC_NONE     = 2'b00,
        TXCFG_SRC_ENVELOPE = 2'b01,
        TXCFG_SRC_EXTERNAL = 2'b10,
        TXCFG_SRC_RESERVED = 2'b11
    } txcfg_mod_src_t;

    typedef enum logic [1:0] {
        TXCFG_CRC5     = 2'b00,
        TXCFG_CRC8     = 2'b01,
        TXCFG_CRC16    = 2'b10,
        TXCFG_CRC_RSVD = 2'b11
    } txcfg_crc_kind_t;

    localparam logic [2:0] TXCFG_CLK_UNSUP_A = 3'h3;
    localparam logic [2:0] TXCFG_CLK_UNSUP_B = 3'h6;

    // carrier reduction below driver supply, millivolts
    localparam logic [9:0] TXCFG_RED_MV_0 = 10'h064;
    localparam logic [9:0] TXCFG_RED_MV_1 = 10'h0fa;
    localparam logic [9:0] TXCFG_RED_MV_2 = 10'h1f4;
    localparam logic [9:0] TXCFG_RED_MV_3 = 10'h3e8;

    // crc presets by selector, 16/8/5 bit generators
    localparam logic [15:0] TXCFG_P16_1 = 16'h6363;
    localparam logic [15:0] TXCFG_P16_2 = 16'ha671;
    localparam logic [15:0] TXCFG_P16_3 = 16'hfffe;
    localparam logic [15:0] TXCFG_P16_7 = 16'hffff;
    localparam logic [7:0]  TXCFG_P8_1  = 8'h12;
    localparam logic [7:0]  TXCFG_P8_2  = 8'hbf;
    localparam logic [7:0]  TXCFG_P8_3  = 8'hfd;
    localparam logic [7:0]  TXCFG_P8_7  = 8'hff;
    localparam logic [4:0]  TXCFG_P5_1  = 5'h12;
    localparam logic [4:0]  TXCFG_P5_7  = 5'h1f;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] driver_clock_mode_sel;
        logic       clock_mode_unsupported;
        logic [9:0] carrier_reduction_mv;
        logic       carrier_full_level;
        logic [4:0] residual_carrier;
        logic [3:0] overshoot_extra_length;
        logic [3:0] overshoot_first_value;
        logic [3:0] load_current_trim;
    } txcfg_drv_cfg_t;

    typedef struct packed {
        logic [1:0]  tx_crc_kind;
        logic [15:0] tx_crc_preset;
        logic        tx_crc_preset_user;
        logic        tx_crc_preset_undef;
        logic        tx_crc_complement;
        logic        tx_crc_append;
    } txcfg_crc_cfg_t;

endpackage : txcfg_pkg

// [design/txcfg_top.sv]
// Summary of operation
// - bit 7 inverts antenna driver two
// - bit 6 inverts antenna driver one
// - bit 3 enables both drivers together
// - reduction field picks 100/250/500/1000 mV
// - full level bit overrides reduction field
// - five-bit residual carrier level held
// - bits 7-4 set overshoot extra length
// - invert bit inverts selected modulation
// - source: none, envelope, external, reserved
// - bits 7-4 hold first overshoot value
// - bits 3-0 hold load current trim
// - preset selector picks initial crc value
// - crc kind selects 5, 8, 16
// - complement bit inverts crc before append
// - append bit adds crc to stream
// - preset table values, user, undefined codes
`timescale 1ns/1ns
`default_nettype none
module txcfg_top
    import txcfg_pkg::*;
(
    input  wire logic        clock,           // system clock, 10 MHz
    input  wire logic        rst,             // synchronous reset, high
    input  wire logic [7:0]  reg_addr,        // register address
    input  wire logic        reg_wr,          // write strobe
    input  wire logic [7:0]  reg_wdata,       // write data
    input  wire logic        reg_rd,          // read strobe
    output logic      [7:0]  reg_rdata,       // read data
    output logic             reg_rvalid,      // read data valid
    input  wire logic        coded_envelope,  // internal tx envelope
    input  wire logic        external_mod_input, // external modulation
    input  wire logic        carrier_in,      // carrier to drivers
    input  wire logic [15:0] user_preset,     // preset from nvm
    output logic             antenna_driver_one, // driver one level
    output logic             antenna_driver_two, // driver two level
    output logic             driver_one_oe_n, // driver one enable
    output logic             driver_two_oe_n, // driver two enable
    output logic             modulation,      // modulation to drivers
    output txcfg_drv_cfg_t   drv_cfg,         // analog driver setup
    output txcfg_crc_cfg_t   crc_cfg          // crc generator setup
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] driver_mode_reg;
    logic [7:0] carrier_amplitude_reg;
    logic [7:0] modulation_control_reg;
    logic [7:0] overshoot_load_trim_reg;
    logic [7:0] tx_crc_setup_reg;
    logic [7:0] rdata_next;

    always_ff @(posedge clock) begin
        if (rst) begin
            driver_mode_reg         <= TXCFG_RST_VALUE;
            carrier_amplitude_reg   <= TXCFG_RST_VALUE;
            modulation_control_reg  <= TXCFG_RST_VALUE;
            overshoot_load_trim_reg <= TXCFG_RST_VALUE;
            tx_crc_setup_reg        <= TXCFG_RST_VALUE;
        end else if (reg_wr) begin
            case (reg_addr)
                TXCFG_ADDR_DRIVER_MODE: begin
                    driver_mode_reg <= reg_wdata & TXCFG_MASK_DRIVER_MODE;
                end
                TXCFG_ADDR_CARRIER_AMP: begin
                    carrier_amplitude_reg <= reg_wdata & TXCFG_MASK_CARRIER_AMP;
                end
                TXCFG_ADDR_MOD_CONTROL: begin
                    modulation_control_reg <= reg_wdata & TXCFG_MASK_MOD_CONTROL;
                end
                TXCFG_ADDR_OVERSHOOT: begin
                    overshoot_load_trim_reg <= reg_wdata & TXCFG_MASK_OVERSHOOT;
                end
                TXCFG_ADDR_TX_CRC_SETUP: begin
                    tx_crc_setup_reg <= reg_wdata & TXCFG_MASK_TX_CRC_SETUP;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            TXCFG_ADDR_DRIVER_MODE:  rdata_next = driver_mode_reg;
            TXCFG_ADDR_CARRIER_AMP:  rdata_next = carrier_amplitude_reg;
            TXCFG_ADDR_MOD_CONTROL:  rdata_next = modulation_control_reg;
            TXCFG_ADDR_OVERSHOOT:    rdata_next = overshoot_load_trim_reg;
            TXCFG_ADDR_TX_CRC_SETUP: rdata_next = tx_crc_setup_reg;
            default:                 rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    logic                  invert_driver_two;
    logic                  invert_driver_one;
    logic                  drivers_on;
    logic [2:0]            driver_clock_mode_sel;
    logic [1:0]            carrier_level_reduction;
    logic                  carrier_full_level;
    logic                  modulation_invert;
    txcfg_mod_src_t        modulation_source;
    logic [2:0]            tx_crc_preset_sel;
    txcfg_crc_kind_t       tx_crc_kind;
    logic                  mod_raw;
    logic [9:0]            reduction_mv;
    logic [15:0]           preset_value;
    logic                  preset_undef;

    assign invert_driver_two       = driver_mode_reg[TXCFG_BIT_INV_TWO];
    assign invert_driver_one       = driver_mode_reg[TXCFG_BIT_INV_ONE];
    assign drivers_on              = driver_mode_reg[TXCFG_BIT_DRV_ON];
    assign driver_clock_mode_sel   = driver_mode_reg[2:0];
    assign carrier_level_reduction = carrier_amplitude_reg[7:6];
    assign carrier_full_level  = modulation_control_reg[TXCFG_BIT_FULL_LEVEL];
    assign modulation_invert   = modulation_control_reg[TXCFG_BIT_MOD_INV];
    assign modulation_source   = txcfg_mod_src_t'(modulation_control_reg[1:0]);
    assign tx_crc_preset_sel   = tx_crc_setup_reg[6:4];
    assign tx_crc_kind         = txcfg_crc_kind_t'(tx_crc_setup_reg[3:2]);

    always_comb begin
        case (modulation_source)
            TXCFG_SRC_ENVELOPE: mod_raw = coded_envelope;
            TXCFG_SRC_EXTERNAL: mod_raw = external_mod_input;
            default:            mod_raw = 1'b0;
        endcase
    end

    always_comb begin
        case (carrier_level_reduction)
            2'b00:   reduction_mv = TXCFG_RED_MV_0;
            2'b01:   reduction_mv = TXCFG_RED_MV_1;
            2'b10:   reduction_mv = TXCFG_RED_MV_2;
            default: reduction_mv = TXCFG_RED_MV_3;
        endcase
    end

    // preset by generator width; undefined codes give zero and a flag
    always_comb begin
        preset_value = 16'h0000;
        preset_undef = 1'b0;
        case (tx_crc_preset_sel)
            3'h0: preset_value = 16'h0000;
            3'h1: begin
                case (tx_crc_kind)
                    TXCFG_CRC16: preset_value = TXCFG_P16_1;
                    TXCFG_CRC8:  preset_value = {8'h00, TXCFG_P8_1};
                    default:     preset_value = {11'h000, TXCFG_P5_1};
                endcase
            end
            3'h2, 3'h3: begin
                case (tx_crc_kind)
                    TXCFG_CRC16: preset_value = tx_crc_preset_sel[0] ?
                                                TXCFG_P16_3 : TXCFG_P16_2;
                    TXCFG_CRC8:  preset_value = {8'h00, tx_crc_preset_sel[0] ?
                                                TXCFG_P8_3 : TXCFG_P8_2};
                    default:     preset_undef = 1'b1;
                endcase
            end
            3'h6: preset_value = user_preset;
            3'h7: begin
                case (tx_crc_kind)
                    TXCFG_CRC16: preset_value = TXCFG_P16_7;
                    TXCFG_CRC8:  preset_value = {8'h00, TXCFG_P8_7};
                    default:     preset_value = {11'h000, TXCFG_P5_7};
                endcase
            end
            default: preset_undef = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // driver pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            antenna_driver_one <= 1'b0;
            antenna_driver_two <= 1'b0;
            driver_one_oe_n    <= 1'b1;
            driver_two_oe_n    <= 1'b1;
            modulation         <= 1'b0;
        end else begin
            antenna_driver_one <= carrier_in ^ invert_driver_one;
            antenna_driver_two <= carrier_in ^ invert_driver_two;
            driver_one_oe_n    <= ~drivers_on;
            driver_two_oe_n    <= ~drivers_on;
            modulation         <= mod_raw ^ modulation_invert;
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            drv_cfg <= '0;
        end else begin
            drv_cfg.driver_clock_mode_sel <= driver_clock_mode_sel;
            // flags codes software must not use
            drv_cfg.clock_mode_unsupported <=
                (driver_clock_mode_sel == TXCFG_CLK_UNSUP_A) ||
                (driver_clock_mode_sel == TXCFG_CLK_UNSUP_B);
            drv_cfg.carrier_reduction_mv <=
                carrier_full_level ? 10'h000 : reduction_mv;
            drv_cfg.carrier_full_level <= carrier_full_level;
            drv_cfg.residual_carrier <= carrier_amplitude_reg[4:0];
            drv_cfg.overshoot_extra_length <=
                modulation_control_reg[7:4];
            drv_cfg.overshoot_first_value <=
                overshoot_load_trim_reg[7:4];
            drv_cfg.load_current_trim <=
                overshoot_load_trim_reg[3:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            crc_cfg <= '0;
        end else begin
            crc_cfg.tx_crc_kind         <= tx_crc_kind;
            crc_cfg.tx_crc_preset       <= preset_value;
            crc_cfg.tx_crc_preset_user  <= (tx_crc_preset_sel == 3'h6);
            crc_cfg.tx_crc_preset_undef <= preset_undef;
            crc_cfg.tx_crc_complement   <=
                tx_crc_setup_reg[TXCFG_BIT_CRC_COMPL];
            crc_cfg.tx_crc_append       <=
                tx_crc_setup_reg[TXCFG_BIT_CRC_APPEND];
        end
    end

endmodule : txcfg_top
`default_nettype wire

// [verification/test_txcfg_top.sv]
`timescale 1ns/1ns
`default_nettype none
module test_txcfg_top;
    import txcfg_pkg::*;
    logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic env = 0, ext = 0, car = 0, reg_rvalid, d1, d2, o1n, o2n, modl;
    logic s1, s2;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [15:0] upre = 16'h0000;
    txcfg_drv_cfg_t dc;
    txcfg_crc_cfg_t cc;
    int err_count = 0;
    int n_checks = 0;
    logic [7:0] expq[$];
    logic [15:0] mv[4] = '{16'h0064, 16'h00fa, 16'h01f4, 16'h03e8};
    logic [15:0] t16[8] = '{0, 16'h6363, 16'ha671, 16'hfffe, 0, 0, 0, 16'hffff};
    logic [15:0] t8[8] = '{0, 16'h0012, 16'h00bf, 16'h00fd, 0, 0, 0, 16'h00ff};
    logic [15:0] t5[8] = '{0, 16'h0012, 0, 0, 0, 0, 0, 16'h001f};
    always #50 clock = ~clock;
    txcfg_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .coded_envelope(env), .external_mod_input(ext), .carrier_in(car),
        .user_preset(upre), .antenna_driver_one(d1), .antenna_driver_two(d2),
        .driver_one_oe_n(o1n), .driver_two_oe_n(o2n), .modulation(modl),
        .drv_cfg(dc), .crc_cfg(cc));
    txcfg_card card (.clock(clock), .pin_one(d1), .pin_two(d2),
        .oe_one_n(o1n), .oe_two_n(o2n), .seen_one(s1), .seen_two(s2));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [7:0] msk(logic [7:0] a);
        case (a)
            8'h28: return 8'hcf;
            8'h29: return 8'hdf;
            8'h2a, 8'h2b: return 8'hff;
            8'h2c: return 8'h7f;
            default: return 8'h00;
        endcase
    endfunction : msk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clock);
        reg_wr = 0;
        @(negedge clock);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr = a;
        reg_rd = 1;
        expq.push_back(e);
        @(negedge clock);
        reg_rd = 0;
        @(negedge clock);
    endtask : rd
    task automatic results();
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    // read results against the oldest note
    always @(negedge clock) begin
        if (reg_rvalid === 1'b1 && expq.size() != 0)
            chk("reg_rdata", 16'(expq.pop_front()), 16'(reg_rdata));
    end
    initial begin
        #1000000;
        err_count++;
        results();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] a, d;
        logic [2:0] v, p;
        logic [1:0] s;
        logic e, u;
        void'($urandom(81426));
        upre = 16'($urandom());
        repeat (5) @(negedge clock);
        rst = 0;
        chk("oe_n", 16'h0003, 16'({o1n, o2n}));
        for (int i = 0; i < 5; i++)
            rd(8'h28 + 8'(i), 8'h00);
        for (int k = 0; k < 20; k++) begin
            a = 8'h27 + 8'($urandom_range(6));
            d = 8'($urandom());
            if (a == 8'h28 && (d[2:0] == 3'h3 || d[2:0] == 3'h6))
                d[2:0] = 3'h1;
            wr(a, d);
            rd(a, d & msk(a));
        end
        for (int m = 0; m < 16; m++) begin
            car = m[3];
            d = {m[1], m[0], 2'b11, m[2], 3'b001};
            wr(8'h28, d);
            chk("drv_one", 16'(car ^ d[6]), 16'(d1));
            chk("drv_two", 16'(car ^ d[7]), 16'(d2));
            chk("oe_n", 16'({2{!d[3]}}), 16'({o1n, o2n}));
            chk("clk_mode", 16'({1'b0, d[2:0]}), 16'({dc.clock_mode_unsupported,
                dc.driver_clock_mode_sel}));
            if (d[3])
                chk("card", 16'({car ^ d[7], car ^ d[6]}), 16'({s2, s1}));
        end
        for (int m = 0; m < 24; m++) begin
            s = 2'(m % 4);
            v = 3'(m / 3);
            env = v[1];
            ext = v[2];
            d = {4'($urandom()), 1'($urandom()), v[0], s};
            wr(8'h2a, d);
            e = s == 2'b01 ? env : s == 2'b10 ? ext : 1'b0;
            chk("modulation", 16'(e ^ v[0]), 16'(modl));
            chk("extra_len", 16'(d[7:4]), 16'(dc.overshoot_extra_length));
        end
        for (int r = 0; r < 8; r++) begin
            wr(8'h2a, {4'h0, r[2], 3'h0});
            d = {r[1:0], 1'b1, 5'($urandom())};
            wr(8'h29, d);
            chk("reduction", r[2] ? 16'h0000 : mv[r[1:0]],
                16'(dc.carrier_reduction_mv));
            chk("residual", 16'(d[4:0]), 16'(dc.residual_carrier));
            d = 8'($urandom());
            wr(8'h2b, d);
            chk("trim", 16'(d), 16'({dc.overshoot_first_value,
                dc.load_current_trim}));
        end
        for (int m = 0; m < 24; m++) begin
            p = 3'(m % 8);
            d = {1'b1, p, 2'(m / 8), 2'($urandom())};
            wr(8'h2c, d);
            u = p == 3'h4 || p == 3'h5 || (m < 8 && p[2:1] == 2'b01);
            chk("undef", 16'(u), 16'(cc.tx_crc_preset_undef));
            chk("user", 16'(p == 3'h6), 16'(cc.tx_crc_preset_user));
            if (p != 3'h6)
                chk("preset", m > 15 ? t16[p] : m > 7 ? t8[p] : t5[p],
                    cc.tx_crc_preset);
            chk("crc_bits", 16'(d[3:0]), 16'({cc.tx_crc_kind,
                cc.tx_crc_complement, cc.tx_crc_append}));
            rd(8'h2c, d & 8'h7f);
        end
        for (int t = 0; t < 8 && expq.size() != 0; t++)
            @(negedge clock);
        if (expq.size() != 0)
            err_count++;
        results();
    end
endmodule : test_txcfg_top
`default_nettype wire

// [verification/txcfg_card.sv]
`timescale 1ns/1ns
`default_nettype none
module txcfg_card
(
    input  wire logic clock,    // system clock
    input  wire logic pin_one,  // driver one level
    input  wire logic pin_two,  // driver two level
    input  wire logic oe_one_n, // driver one enable
    input  wire logic oe_two_n, // driver two enable
    output var  logic seen_one, // level at card
    output var  logic seen_two  // level at card
);
    // ----------------------------------------
    // field seen by the card
    // ----------------------------------------
    logic last_one;
    logic last_two;
    always_ff @(posedge clock) begin
        if (!oe_one_n) last_one <= pin_one;
        if (!oe_two_n) last_two <= pin_two;
    end
    // released pin must not look like a held level
    always_comb begin
        seen_one = oe_one_n ? ~last_one : pin_one;
        seen_two = oe_two_n ? ~last_two : pin_two;
    end
endmodule : txcfg_card
`default_nettype wire

// [verification/txcfg_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module txcfg_sva
    import txcfg_pkg::*;
(
    input wire logic           clock,              // clock
    input wire logic           rst,                // reset
    input wire logic [7:0]     reg_addr,           // address
    input wire logic           reg_wr,             // write
    input wire logic [7:0]     reg_wdata,          // wdata
    input wire logic           reg_rd,             // read
    input wire logic [7:0]     reg_rdata,          // rdata
    input wire logic           reg_rvalid,         // rvalid
    input wire logic           coded_envelope,     // envelope
    input wire logic           external_mod_input, // ext mod
    input wire logic           carrier_in,         // carrier
    input wire logic           antenna_driver_one, // pin one
    input wire logic           antenna_driver_two, // pin two
    input wire logic           driver_one_oe_n,    // enable one
    input wire logic           driver_two_oe_n,    // enable two
    input wire logic           modulation,         // modulation
    input wire txcfg_drv_cfg_t drv_cfg,            // driver setup
    input wire txcfg_crc_cfg_t crc_cfg             // crc setup
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic [7:0] w1;
    logic [7:0] w2;
    always_ff @(posedge clock) begin
        w1 <= reg_wdata;
        w2 <= w1;
    end
    wire w28 = reg_wr && reg_addr == 8'h28;
    wire w29 = reg_wr && reg_addr == 8'h29;
    wire w2a = reg_wr && reg_addr == 8'h2a;
    wire w2b = reg_wr && reg_addr == 8'h2b;
    wire w2c = reg_wr && reg_addr == 8'h2c;
    function automatic logic [7:0] rmask(input logic [7:0] a);
        case (a)
            8'h28: return 8'hcf;
            8'h29: return 8'hdf;
            8'h2a, 8'h2b: return 8'hff;
            8'h2c: return 8'h7f;
            default: return 8'h00;
        endcase
    endfunction : rmask
    function automatic logic [9:0] red(input logic [1:0] c);
        return c == 2'h0 ? 10'h064 : c == 2'h1 ? 10'h0fa :
               c == 2'h2 ? 10'h1f4 : 10'h3e8;
    endfunction : red
    function automatic logic [15:0] p16(input logic [2:0] s);
        case (s)
            3'h1: return 16'h6363;
            3'h2: return 16'ha671;
            3'h3: return 16'hfffe;
            3'h7: return 16'hffff;
            default: return 16'h0000;
        endcase
    endfunction : p16
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_drv_two_inv:
    assert property (w28 ##1 !w28 |=> antenna_driver_two ==
        ($past(carrier_in) ^ w2[7])) else $error("driver two level wrong");
    chk_drv_one_inv:
    assert property (w28 ##1 !w28 |=> antenna_driver_one ==
        ($past(carrier_in) ^ w2[6])) else $error("driver one level wrong");
    chk_oe_pair:
    assert property (w28 ##1 !w28 |=> driver_one_oe_n == !w2[3] &&
        driver_two_oe_n == !w2[3]) else $error("driver enable wrong");
    chk_read_back:
    assert property (reg_rd |=> reg_rvalid &&
        (reg_rdata & ~rmask($past(reg_addr))) == 8'h00)
        else $error("read data wrong");
    chk_rvalid_pulse:
    assert property (!reg_rd |=> !reg_rvalid) else $error("stray rvalid");
    chk_mod_select:
    assert property (w2a ##1 !w2a |=> w2[1:0] == 2'b11 || modulation ==
        (w2[2] ^ (w2[1:0] == 2'b01 ? $past(coded_envelope) :
        w2[1] & $past(external_mod_input)))) else $error("modulation wrong");
    chk_modulation_control_fields:
    assert property (w2a ##1 !w2a |=> drv_cfg.carrier_full_level == w2[3]
        && drv_cfg.overshoot_extra_length == w2[7:4])
        else $error("control fields wrong");
    chk_amp_fields:
    assert property (w29 ##1 !w29 |=> drv_cfg.residual_carrier == w2[4:0]
        && drv_cfg.carrier_reduction_mv == (drv_cfg.carrier_full_level ?
        10'h000 : red(w2[7:6]))) else $error("amplitude fields wrong");
    chk_trim_fields:
    assert property (w2b ##1 !w2b |=> {drv_cfg.overshoot_first_value,
        drv_cfg.load_current_trim} == w2) else $error("trim fields wrong");
    chk_crc_fields:
    assert property (w2c ##1 !w2c |=> {crc_cfg.tx_crc_kind,
        crc_cfg.tx_crc_complement, crc_cfg.tx_crc_append} == w2[3:0] &&
        crc_cfg.tx_crc_preset_user == (w2[6:4] == 3'h6))
        else $error("crc fields wrong");
    chk_crc16_preset:
    assert property (w2c ##1 !w2c ##1 crc_cfg.tx_crc_kind == 2'b10 |->
        w2[6:4] == 3'h6 || crc_cfg.tx_crc_preset == p16(w2[6:4]))
        else $error("crc preset wrong");
    cover property (w28 ##1 !w28 ##1 !driver_one_oe_n);
    cover property (reg_rd && reg_addr == 8'h2d);
    cover property (crc_cfg.tx_crc_preset_undef);
endmodule : txcfg_sva
bind txcfg_top txcfg_sva chk_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .coded_envelope(coded_envelope), .carrier_in(carrier_in),
    .external_mod_input(external_mod_input), .modulation(modulation),
    .antenna_driver_one(antenna_driver_one), .drv_cfg(drv_cfg),
    .antenna_driver_two(antenna_driver_two), .crc_cfg(crc_cfg),
    .driver_one_oe_n(driver_one_oe_n), .driver_two_oe_n(driver_two_oe_n));
`default_nettype wire
